// *** bench/adc_status_mode_registers_test.sv ***
`default_nettype none
module adc_status_mode_registers_test
  import adcsm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and instances.
  // ****************************************************************
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic conv_done = 1'b0;
  logic conv_clamp = 1'b0;
  logic pre_update = 1'b0;
  logic ref_low = 1'b0;
  logic ref_detect_en_en = 1'b0;
  logic [2:0] chan = 3'h0;
  wire sclk, cs_n, din, dout, dout_oe, drdy_n, mod_rst, low_sw, pwr_down, clamp_hi;
  wire [2:0] op_mode;
  wire [3:0] rate_sel;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'h77b1;
  int i;
  logic [23:0] rd;
  logic [7:0] st;
  logic [15:0] m;
  logic [15:0] mv;
  logic cl;

  adcsm_regs i_dut (.MCLK(mclk), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
    .DOUT_OE(dout_oe), .DRDY_N(drdy_n), .CONV_DONE(conv_done), .CONV_CLAMP(conv_clamp),
    .PRE_UPDATE(pre_update), .REF_LOW(ref_low), .REF_DETECT_EN_EN(ref_detect_en_en), .ACTIVE_CHAN(chan),
    .MOD_RST(mod_rst), .OP_MODE(op_mode), .RATE_SEL(rate_sel), .LOW_SW(low_sw),
    .PWR_DOWN(pwr_down), .CLAMP_HI(clamp_hi));
  adcsm_host i_host (.SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout));

  // Master clock at 50 MHz.
  always #10 mclk = ~mclk;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  task automatic close_out();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits n MCLK edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // Expected status byte from the live flags.
  function automatic logic [7:0] st_exp(input logic r, input logic e, input logic f, input logic [2:0] c);
    return {r, e, f, 1'b0, VARIANT_24, c};
  endfunction

  task automatic rd_st(output logic [7:0] s);
    i_host.xfer(0, {2'b01, REG_STATUS, 3'b000}, 24'h000000, 8, rd);
    s = rd[7:0];
    tick(2);
  endtask

  task automatic rd_mode(output logic [15:0] v);
    i_host.xfer(0, {2'b01, REG_MODE, 3'b000}, 24'h000000, 16, rd);
    v = rd[15:0];
    tick(2);
  endtask

  // Writes the mode word and expects one modulator reset pulse within a bound.
  task automatic wr_mode(input logic [15:0] v);
    int k;
    logic seen;
    seen = 1'b0;
    i_host.xfer(0, {2'b00, REG_MODE, 3'b000}, {8'h00, v}, 16, rd);
    for (k = 0; k < 20 && !seen; k++)
    begin
      tick(1);
      seen = (mod_rst === 1'b1);
    end
    check(seen, 1'b1);
    if (!seen)
      close_out();
    tick(2);
  endtask

  task automatic conv(input logic c);
    conv_done = 1'b1;
    conv_clamp = c;
    tick(1);
    conv_done = 1'b0;
    tick(3);
  endtask

  // A hang is cut short and counted.
  initial
  begin
    #500us;
    errors++;
    close_out();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge mclk);
    #2 rstn = 1'b1;
    tick(4);
    check({dout_oe, dout}, 2'b00);
    rd_st(st);
    check(st, STATUS_RST);
    rd_mode(m);
    check(m, MODE_RST);
    check({op_mode, rate_sel, low_sw, pwr_down, clamp_hi, drdy_n}, {3'h0, 4'hA, 4'h0});
    // A write to address zero is taken as a new address byte, here a status read.
    i_host.xfer(0, 8'h00, 24'h004000, 16, rd);
    check(rd[7:0], STATUS_RST);
    tick(2);
    i_host.xfer(3, {2'b01, REG_STATUS, 3'b000}, 24'h000000, 8, rd);
    check(rd[7:0], STATUS_RST);
    tick(2);
    // Random results, each followed by a data read or a pre-update warning.
    for (i = 0; i < 8; i++)
    begin
      cl = 1'($random(seed));
      chan = 3'($random(seed));
      tick(1);
      conv(cl);
      check(drdy_n, 1'b1);
      rd_st(st);
      check(st, st_exp(1'b0, cl, 1'b0, chan));
      if (i % 2)
      begin
        i_host.xfer(0, {2'b01, REG_DATA, 3'b000}, 24'h000000, int'(LEN_DATA), rd);
        tick(8);
      end
      else
      begin
        pre_update = 1'b1;
        tick(1);
        pre_update = 1'b0;
        tick(2);
      end
      rd_st(st);
      check(st, st_exp(1'b1, cl, 1'b0, chan));
    end
    // Random mode words with the reserved bits held at zero.
    for (i = 0; i < 6; i++)
    begin
      mv = {3'h0, 1'($random(seed)), 8'h00, 4'($random(seed))};
      conv(1'b1);
      wr_mode(mv);
      rd_st(st);
      check(st, st_exp(1'b1, 1'b0, 1'b0, chan));
      rd_mode(m);
      check(m, mv);
      check({op_mode, low_sw, rate_sel}, {mv[15:12], mv[3:0]});
    end
    // A frame cut short after eight data bits leaves the mode unchanged.
    i_host.xfer(0, {2'b00, REG_MODE, 3'b000}, 24'h0000F0, 8, rd);
    tick(10);
    rd_mode(m);
    check(m, mv);
    // Single conversion, then power-down opens the switch.
    wr_mode(16'h300A);
    check({op_mode, low_sw}, {OPM_SINGLE, 1'b1});
    conv(1'b0);
    tick(3);
    check({pwr_down, low_sw}, 2'b10);
    rd_st(st);
    check(st, st_exp(1'b0, 1'b0, 1'b0, chan));
    wr_mode({OPM_POWER_DOWN, 1'b1, 8'h00, 4'hA});
    check({pwr_down, low_sw}, 2'b10);
    rd_st(st);
    check(st[ST_RDY], 1'b1);
    wr_mode(MODE_RST);
    check(pwr_down, 1'b0);
    // Missing reference, with detection off and then on.
    ref_low = 1'b1;
    tick(8);
    check(clamp_hi, 1'b0);
    rd_st(st);
    check(st[ST_REFM], 1'b0);
    ref_detect_en_en = 1'b1;
    tick(8);
    check(clamp_hi, 1'b1);
    rd_st(st);
    check(st[ST_ERR:ST_REFM], 2'b11);
    ref_low = 1'b0;
    tick(8);
    check(clamp_hi, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire

// *** bench/adcsm_host.sv ***
`default_nettype none
module adcsm_host
(
  output logic SCLK,
  output logic CS_N,
  output logic DIN,
  input wire logic DOUT
);
  timeunit 1ns;
  timeprecision 1ps;

  // The serial clock idles high; it runs inside a frame and for a short lead-in before one.
  initial
  begin
    SCLK = 1'b1;
    CS_N = 1'b1;
    DIN = 1'b0;
  end

  // Sends leading ones, an address byte and n data bits, MSB first; captures DOUT on rising edges.
  task automatic xfer(input int pre, input logic [7:0] ab, input logic [23:0] wd, input int n,
                      output logic [23:0] rd);
    logic [31:0] sh;
    int i;
    sh = {ab, wd << (24 - n)};
    rd = 24'h000000;
    // Lead-in clocks with the select high let the device refresh its read snapshot before the frame.
    for (i = 0; i < 20; i++)
    begin
      #15 SCLK = 1'b0;
      #15 SCLK = 1'b1;
    end
    #15 CS_N = 1'b0;
    for (i = 0; i < pre + 8 + n; i++)
    begin
      #15 SCLK = 1'b0;
      DIN = (i < pre) ? 1'b1 : sh[31 - (i - pre)];
      #15 SCLK = 1'b1;
      if (i >= pre + 8)
      begin
        rd = {rd[22:0], DOUT};
      end
    end
    #15 CS_N = 1'b1;
    DIN = ~DIN; // Released line shows the inverse of its last value.
    #30;
  endtask
endmodule
`default_nettype wire

// *** hdl/adcsm_pkg.sv ***
`default_nettype none
package adcsm_pkg;

  // ****************************************************************
  // Register select codes carried by the address byte.
  // ****************************************************************
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_CONFIG = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_ID = 3'h4;
  localparam logic [2:0] REG_IO = 3'h5;

  // ****************************************************************
  // Reset values, write mask and field positions.
  // ****************************************************************
  localparam logic [7:0] STATUS_RST = 8'h88;
  localparam logic [15:0] MODE_RST = 16'h000A;
  localparam logic [15:0] MODE_WMASK = 16'hF00F;
  localparam logic VARIANT_24 = 1'h1;
  localparam int ST_RDY = 7;
  localparam int ST_ERR = 6;
  localparam int ST_REFM = 5;
  localparam int AB_RW = 6;
  localparam int AB_RS_MSB = 5;
  localparam int AB_RS_LSB = 3;

  // Operating mode codes; power-down is decoded exactly, and unlisted codes run as continuous.
  localparam logic [2:0] OPM_CONTINUOUS = 3'h0;
  localparam logic [2:0] OPM_SINGLE = 3'h1;
  localparam logic [2:0] OPM_POWER_DOWN = 3'h3;

  // Serial bit counts.
  localparam logic [4:0] ADDR_LAST = 5'h07;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_24 = 5'h18;
  localparam logic [4:0] LEN_DATA = VARIANT_24 ? LEN_24 : LEN_16;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef struct packed {
    logic [2:0] op_mode_sel;
    logic low_side_switch;
    logic [7:0] must_be_zero;
    logic [3:0] update_rate_sel;
  } adcsm_mode_t;

  typedef struct packed {
    logic [7:0] status;
    logic [15:0] mode;
  } adcsm_snap_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'b0001,
    PH_WRITE = 4'b0010,
    PH_READ = 4'b0100,
    PH_SKIP = 4'b1000
  } adcsm_phase_t;

  // Returns the data length in bits of the register selected.
  function automatic logic [4:0] reg_bits(input logic [2:0] rs);
    logic [4:0] n;
    n = LEN_DATA;
    if (rs == REG_STATUS || rs == REG_ID || rs == REG_IO)
    begin
      n = LEN_8;
    end
    else if (rs == REG_MODE || rs == REG_CONFIG)
    begin
      n = LEN_16;
    end
    return n;
  endfunction

endpackage
`default_nettype wire

// *** hdl/adcsm_regs.sv ***
`default_nettype none
module adcsm_regs
  import adcsm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  output logic DRDY_N,
  input wire logic CONV_DONE,
  input wire logic CONV_CLAMP,
  input wire logic PRE_UPDATE,
  input wire logic REF_LOW,
  input wire logic REF_DETECT_EN_EN,
  input wire logic [2:0] ACTIVE_CHAN,
  output logic MOD_RST,
  output logic [2:0] OP_MODE,
  output logic [3:0] RATE_SEL,
  output logic LOW_SW,
  output logic PWR_DOWN,
  output logic CLAMP_HI
);

  // ****************************************************************
  // Reset release.
  // ****************************************************************
  logic rst1_q;
  logic rst2_q;
  wire rst_n = rst2_q;
  wire frame_rst_n = rst2_q & ~CS_N;

  // Releases the reset through two flip-flops.
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst1_q <= 1'h0;
      rst2_q <= 1'h0;
    end
    else
    begin
      rst1_q <= 1'h1;
      rst2_q <= rst1_q;
    end
  end

  // ****************************************************************
  // Serial-clock side declarations.
  // ****************************************************************
  adcsm_phase_t phase_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic [5:0] addr_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [15:0] wr_word_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  logic ack_q;
  logic [2:0] req_sync_q;
  logic req_flt_q;
  adcsm_snap_t snap_q;
  logic dout_q;
  logic dout_oe_q;

  // ****************************************************************
  // Master-clock side declarations.
  // ****************************************************************
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] flt_q;
  logic [15:0] mode_q;
  logic busy_q;
  logic rdy_q;
  logic err_q;
  logic refm_q;
  logic [2:0] chan_q;
  logic pd_q;
  logic pub_req_q;
  adcsm_snap_t pub_q;
  logic mod_rst_q;
  logic low_sw_q;
  logic drdy_n_q;

  // ****************************************************************
  // Master-clock synchronisers.
  // ****************************************************************
  // A bit of the filtered vector follows only when stages two and three agree.
  wire [3:0] sync_in = {REF_LOW, wr_tgl_q, rd_tgl_q, ack_q};
  wire [3:0] stable = ~(s2_q ^ s3_q);
  wire [3:0] flt_d = (flt_q & ~stable) | (s3_q & stable);
  wire [3:0] chg = flt_d ^ flt_q;
  wire ref_low_f = flt_q[3];
  wire mode_evt = chg[2];
  wire read_evt = chg[1];
  wire ack_f = flt_q[0];

  // Three-stage sampling of the reference flag and the serial-side toggles.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      flt_q <= 4'h0;
    end
    else
    begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // ****************************************************************
  // Mode register and converter control.
  // ****************************************************************
  // The written word is held still on the serial side until the next write.
  wire [15:0] mode_d = mode_evt ? (wr_word_q & MODE_WMASK) : mode_q;
  wire adcsm_mode_t mode_f = adcsm_mode_t'(mode_d);
  wire start_single = mode_evt && mode_f.op_mode_sel == OPM_SINGLE;
  wire busy_d = start_single | (busy_q & ~CONV_DONE & ~mode_evt);
  wire pd_d = (mode_f.op_mode_sel == OPM_POWER_DOWN) | ((mode_f.op_mode_sel == OPM_SINGLE) & ~busy_d);
  wire refm_d = REF_DETECT_EN_EN & ref_low_f;
  wire pd_entry = pd_d & ~pd_q;

  // Ready: mode write wins, then a new result, then the setting events.
  wire rdy_d = mode_evt ? 1'h1 :
    CONV_DONE ? 1'h0 :
    (read_evt | PRE_UPDATE | pd_entry) ? 1'h1 : rdy_q;

  // Error: cleared by a starting write, loaded with each result.
  wire err_d = mode_evt ? 1'h0 :
    CONV_DONE ? (CONV_CLAMP | refm_q) :
    refm_q ? 1'h1 : err_q;

  wire [7:0] status_w = {rdy_q, err_q, refm_q, 1'h0, VARIANT_24, chan_q};

  // Register and output flip-flops of the master domain.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_RST;
      busy_q <= 1'h0;
      rdy_q <= STATUS_RST[ST_RDY];
      err_q <= STATUS_RST[ST_ERR];
      refm_q <= STATUS_RST[ST_REFM];
      chan_q <= 3'h0;
      pd_q <= 1'h0;
      mod_rst_q <= 1'h0;
      low_sw_q <= 1'h0;
      drdy_n_q <= ~STATUS_RST[ST_RDY];
    end
    else
    begin
      mode_q <= mode_d;
      busy_q <= busy_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      refm_q <= refm_d;
      chan_q <= ACTIVE_CHAN;
      pd_q <= pd_d;
      mod_rst_q <= mode_evt;
      low_sw_q <= mode_f.low_side_switch & ~pd_d;
      drdy_n_q <= ~rdy_d;
    end
  end

  // Publishes a status and mode snapshot whenever the last one was taken.
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pub_req_q <= 1'h0;
      pub_q <= '0;
    end
    else if (pub_req_q == ack_f)
    begin
      pub_req_q <= ~pub_req_q;
      pub_q <= '{status: status_w, mode: mode_q};
    end
  end

  // ****************************************************************
  // Serial-clock side: frame decoding.
  // ****************************************************************
  wire last_bit = (cnt_q == len_q - 5'h01);
  wire [7:0] abyte = {1'h0, addr_q, DIN};
  wire a_rd = abyte[AB_RW];
  wire [2:0] a_rs = abyte[AB_RS_MSB:AB_RS_LSB];
  wire addr_done = (phase_q == PH_ADDR) && (cnt_q == ADDR_LAST);
  wire gate_hi = (phase_q == PH_ADDR) && (cnt_q == 5'h00) && DIN;
  wire wr_done = (phase_q == PH_WRITE) && last_bit;
  wire data_rd = addr_done && a_rd && (a_rs == REG_DATA);

  // Address byte, data phases and the transmit shifter.
  always_ff @(posedge SCLK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      phase_q <= PH_ADDR;
      cnt_q <= 5'h00;
      len_q <= LEN_8;
      addr_q <= 6'h00;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
    end
    else
    begin
      rx_q <= {rx_q[14:0], DIN};
      tx_q <= {tx_q[14:0], 1'h0};
      case (phase_q)
        PH_ADDR:
        begin
          if (gate_hi)
          begin
            cnt_q <= 5'h00;
          end
          else if (!addr_done)
          begin
            cnt_q <= cnt_q + 5'h01;
            addr_q <= {addr_q[4:0], DIN};
          end
          else
          begin
            cnt_q <= 5'h00;
            len_q <= reg_bits(a_rs);
            if (!a_rd && a_rs == REG_STATUS)
            begin
              phase_q <= PH_ADDR;
            end
            else if (!a_rd && a_rs == REG_MODE)
            begin
              phase_q <= PH_WRITE;
            end
            else if (a_rd && a_rs == REG_STATUS)
            begin
              phase_q <= PH_READ;
              tx_q <= {snap_q.status, 8'h00};
            end
            else if (a_rd && a_rs == REG_MODE)
            begin
              phase_q <= PH_READ;
              tx_q <= snap_q.mode;
            end
            else
            begin
              phase_q <= PH_SKIP;
            end
          end
        end
        PH_WRITE, PH_READ, PH_SKIP:
        begin
          cnt_q <= last_bit ? 5'h00 : cnt_q + 5'h01;
          if (last_bit)
          begin
            phase_q <= PH_ADDR;
          end
        end
        default:
        begin
          phase_q <= PH_ADDR;
          cnt_q <= 5'h00;
        end
      endcase
    end
  end

  // Events and snapshot capture survive the end of a frame.
  always_ff @(posedge SCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_word_q <= MODE_RST;
      wr_tgl_q <= 1'h0;
      rd_tgl_q <= 1'h0;
      req_sync_q <= 3'h0;
      req_flt_q <= 1'h0;
      ack_q <= 1'h0;
      snap_q <= '0;
    end
    else
    begin
      if (wr_done)
      begin
        wr_word_q <= {rx_q[14:0], DIN};
        wr_tgl_q <= ~wr_tgl_q;
      end
      if (data_rd)
      begin
        rd_tgl_q <= ~rd_tgl_q;
      end
      req_sync_q <= {req_sync_q[1:0], pub_req_q};
      if (req_sync_q[1] == req_sync_q[2])
      begin
        req_flt_q <= req_sync_q[2];
      end
      if (req_flt_q != ack_q)
      begin
        snap_q <= pub_q;
        ack_q <= req_flt_q;
      end
    end
  end

  // Drives the data line on falling edges while the frame is open.
  always_ff @(negedge SCLK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      dout_q <= 1'h0;
      dout_oe_q <= 1'h0;
    end
    else
    begin
      dout_q <= (phase_q == PH_READ) & tx_q[15];
      dout_oe_q <= 1'h1;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign DOUT = dout_q;
  assign DOUT_OE = dout_oe_q;
  assign DRDY_N = drdy_n_q;
  assign MOD_RST = mod_rst_q;
  assign OP_MODE = mode_q[15:13];
  assign RATE_SEL = mode_q[3:0];
  assign LOW_SW = low_sw_q;
  assign PWR_DOWN = pd_q;
  assign CLAMP_HI = refm_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  rdy_clear_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    (CONV_DONE && !mode_evt) |=> !rdy_q && DRDY_N)
    else $error("ready not cleared by new result");

  rdy_read_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    (read_evt && !CONV_DONE) |=> rdy_q)
    else $error("ready not set after data read");

  rdy_pd_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!PWR_DOWN && !CONV_DONE ##1 PWR_DOWN) |-> rdy_q)
    else $error("ready not set on power-down entry");

  pin_mirror_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    DRDY_N == !rdy_q)
    else $error("ready pin disagrees with status");

  err_load_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    (CONV_DONE && CONV_CLAMP && !mode_evt) |=> err_q)
    else $error("clamped result did not flag error");

  err_clear_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    mode_evt |=> !err_q)
    else $error("error not cleared by mode write");

  ref_gate_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    !REF_DETECT_EN_EN |=> !refm_q && !CLAMP_HI)
    else $error("missing reference flagged while disabled");

  mode_apply_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    mode_evt |=> MOD_RST && rdy_q ##1 !MOD_RST)
    else $error("mode write did not restart converter");

  sw_open_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    PWR_DOWN |-> !LOW_SW)
    else $error("switch closed in power-down");

  single_done_a: assert property (@(posedge MCLK) disable iff (!rst_n)
    (busy_q && CONV_DONE && !mode_evt) |=> PWR_DOWN && !rdy_q)
    else $error("single conversion did not hold ready low");

  gate_hold_a: assert property (@(posedge SCLK) disable iff (!frame_rst_n)
    gate_hi |=> phase_q == PH_ADDR && cnt_q == 5'h00)
    else $error("leading one not ignored");

  partial_wr_a: assert property (@(posedge SCLK) disable iff (!frame_rst_n)
    (phase_q == PH_WRITE && !last_bit) |=> $stable(wr_tgl_q) && $stable(wr_word_q))
    else $error("mode word applied before sixteen bits");

endmodule
`default_nettype wire
